//--- bench/bqf_ctrl_model.sv
// Bus controller model that paces bus scans and issues block data queries.
`timescale 1ns/10ps
module bqf_ctrl_model import bqf_pkg::*; #(parameter int SCAN_CYC = 40) (
   input wire logic i_clk,
   input wire logic i_resetn,
   output logic o_scan = 1'b0,
   output logic o_rx_valid = 1'b0,
   output logic [7:0] o_rx_sfc = 8'h00,
   output logic [7:0] o_rx_b0 = 8'h00,
   output logic [7:0] o_rx_b1 = 8'h00,
   output logic [7:0] o_rx_src = 8'h00
);
   int scan_cnt = 0;
   always @(posedge i_clk) begin
      scan_cnt <= (scan_cnt == SCAN_CYC - 1) ? 0 : scan_cnt + 1;
      o_scan <= i_resetn && (scan_cnt == SCAN_CYC - 1);
   end
   // Released request lines show the inverse so a stale value cannot pass.
   task automatic query(input logic [7:0] off, input logic [7:0] len, input logic [7:0] src);
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_sfc <= SFC_QUERY;
      o_rx_b0 <= off;
      o_rx_b1 <= (len > MAX_LEN) ? MAX_LEN : len;
      o_rx_src <= src;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_sfc <= ~o_rx_sfc;
      o_rx_b0 <= ~o_rx_b0;
      o_rx_b1 <= ~o_rx_b1;
      o_rx_src <= ~o_rx_src;
   endtask : query
endmodule : bqf_ctrl_model

//--- bench/tb_top.sv
// Self-checking testbench for the block data query and fault notice engine.
`timescale 1ns/10ps
module tb_top;
   import bqf_pkg::*;
   logic I_CLK = 1'b0, I_RESETN = 1'b0, I_MON_SET = 1'b0, I_MEM_WE = 1'b0, I_FAULT = 1'b0;
   logic I_BLOCK_FAULT = 1'b0, I_REDUNDANT = 1'b0;
   logic [7:0] I_MON_DEV = 8'h00, I_MEM_ADDR = 8'h00, I_MEM_WDATA = 8'h00, I_FAULT_TYPE = 8'h00;
   logic [7:0] I_FAULT_DESC = 8'h00, I_FAULT_CFG = 8'h00, I_CTRL_DEV = 8'h05;
   logic [1:0] I_IOCFG = 2'h1;
   bqf_family_e I_FAMILY = FAM_DISCRETE;
   logic I_SCAN, I_RX_VALID, O_TX_START, O_TX_VALID, O_TX_END, O_BUSY, O_FAULT_DROP;
   logic [7:0] I_RX_SFC, I_RX_B0, I_RX_B1, I_RX_SRC, O_TX_BYTE, O_TX_SFC, O_TX_DEST;
   logic [15:0] exp_hdr[$];
   logic [7:0] exp_byte[$];
   logic exp_end[$];
   logic [7:0] mem[256];
   logic mon_on = 1'b0;
   int error_cnt = 0, tests_run = 0, drop_cnt = 0;
   initial begin
      forever #5 I_CLK = ~I_CLK;
   end
   bqf_ctrl_model ctrl (.i_clk(I_CLK), .i_resetn(I_RESETN), .o_scan(I_SCAN), .o_rx_valid(I_RX_VALID),
      .o_rx_sfc(I_RX_SFC), .o_rx_b0(I_RX_B0), .o_rx_b1(I_RX_B1), .o_rx_src(I_RX_SRC));
   bqf_engine dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SCAN(I_SCAN), .I_RX_VALID(I_RX_VALID),
      .I_RX_SFC(I_RX_SFC), .I_RX_B0(I_RX_B0), .I_RX_B1(I_RX_B1), .I_RX_SRC(I_RX_SRC),
      .I_MON_SET(I_MON_SET), .I_MON_DEV(I_MON_DEV), .I_MEM_WE(I_MEM_WE), .I_MEM_ADDR(I_MEM_ADDR),
      .I_MEM_WDATA(I_MEM_WDATA), .I_FAULT(I_FAULT), .I_FAULT_TYPE(I_FAULT_TYPE), .I_FAULT_DESC(I_FAULT_DESC),
      .I_FAULT_CFG(I_FAULT_CFG), .I_BLOCK_FAULT(I_BLOCK_FAULT), .I_FAMILY(I_FAMILY), .I_IOCFG(I_IOCFG),
      .I_REDUNDANT(I_REDUNDANT), .I_CTRL_DEV(I_CTRL_DEV), .O_TX_START(O_TX_START), .O_TX_VALID(O_TX_VALID),
      .O_TX_BYTE(O_TX_BYTE), .O_TX_SFC(O_TX_SFC), .O_TX_DEST(O_TX_DEST), .O_TX_END(O_TX_END),
      .O_BUSY(O_BUSY), .O_FAULT_DROP(O_FAULT_DROP));
   task automatic chk_hdr(input string what, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk_hdr
   task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk_byte
   task automatic note(input logic [7:0] b, input logic e);
      exp_byte.push_back(b);
      exp_end.push_back(e);
   endtask : note
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // Results are taken off the note queues in the order the engine sends them.
   always @(posedge I_CLK) begin
      if (O_TX_START === 1'b1 && exp_hdr.size() == 0) begin
         error_cnt++;
         $display("ERROR header expected none seen %h", {O_TX_SFC, O_TX_DEST});
      end else if (O_TX_START === 1'b1) begin
         chk_hdr("header", exp_hdr.pop_front(), {O_TX_SFC, O_TX_DEST});
      end
      if (O_TX_VALID === 1'b1 && exp_byte.size() == 0) begin
         error_cnt++;
         $display("ERROR byte expected none seen %h", O_TX_BYTE);
      end else if (O_TX_VALID === 1'b1) begin
         chk_byte("byte", exp_byte.pop_front(), O_TX_BYTE);
         chk_byte("end", {7'h00, exp_end.pop_front()}, {7'h00, O_TX_END});
      end else if (O_TX_END !== 1'b0 && I_RESETN === 1'b1) begin
         chk_byte("end", 8'h00, {7'h00, O_TX_END});
      end
      if (O_FAULT_DROP === 1'b1) drop_cnt++;
   end
   task automatic wait_idle(input string name);
      repeat (3) @(posedge I_CLK);
      for (int i = 0; i < 600; i++) begin
         @(posedge I_CLK);
         if (O_BUSY === 1'b0 && exp_hdr.size() == 0 && exp_byte.size() == 0) begin
            $display("test %s done", name);
            return;
         end
      end
      error_cnt++;
      $display("ERROR %s wait expected idle seen busy", name);
      tally_and_finish();
   endtask : wait_idle
   task automatic do_query(input logic [7:0] off, input logic [7:0] len);
      logic [7:0] src;
      src = 8'(1 + $urandom % 29);
      for (int s = 0; s < len; s += PIECE_BYTES) begin
         exp_hdr.push_back({SFC_ANSWER, src});
         note(off, 1'b0);
         note(len, 1'b0);
         for (int k = s; k < len && k < s + PIECE_BYTES; k++) begin
            note(mem[8'(off + k)], k == len - 1 || k == s + PIECE_BYTES - 1);
         end
      end
      ctrl.query(off, len, src);
      wait_idle("query");
   endtask : do_query
   function automatic logic [7:0] exp_desc(bqf_family_e f, logic [7:0] d);
      if (f == FAM_HSC) return d & (8'h01 << DESC_FAILED_SWITCH);
      if (f != FAM_CS_AIO && f != FAM_CS_AOUT) d[DESC_FEEDBACK] = 1'b0;
      if (f == FAM_CS_AOUT) d = d & ~DESC_UNUSED_AOUT;
      if (f == FAM_CS_AIN) d = d & ~DESC_UNUSED_AIN;
      return d;
   endfunction : exp_desc
   task automatic do_fault(input bqf_family_e f, input logic blk, input logic [1:0] io, input logic twice);
      logic [7:0] typ, desc, cfg, b2;
      typ = 8'($urandom);
      desc = 8'($urandom) | 8'h81;
      cfg = 8'($urandom);
      b2 = blk ? {6'h00, io} : (f == FAM_RTD_TC) ? {cfg[7:2], 2'b01} : cfg;
      if (f == FAM_GATE_ARRAY) b2 = 8'h00;
      if (I_REDUNDANT) exp_hdr.push_back({SFC_FAULT, RED_DEV_A});
      if (I_REDUNDANT) exp_hdr.push_back({SFC_FAULT, RED_DEV_B});
      if (!I_REDUNDANT) exp_hdr.push_back({SFC_FAULT, I_CTRL_DEV});
      if (mon_on) exp_hdr.push_back({SFC_FAULT, I_MON_DEV});
      for (int c = 0; c < 2 + I_REDUNDANT + mon_on - 1; c++) begin
         note(typ, 1'b0);
         note(exp_desc(f, desc), 1'b0);
         note(b2, 1'b1);
      end
      @(posedge I_CLK);
      I_FAMILY <= f;
      I_BLOCK_FAULT <= blk;
      I_IOCFG <= io;
      I_FAULT_TYPE <= typ;
      I_FAULT_DESC <= desc;
      I_FAULT_CFG <= cfg;
      I_FAULT <= 1'b1;
      @(posedge I_CLK);
      I_FAULT <= twice;
      I_FAULT_DESC <= ~desc;
      @(posedge I_CLK);
      I_FAULT <= 1'b0;
      wait_idle("fault");
   endtask : do_fault
   initial begin
      logic [7:0] v;
      void'($urandom(32'h41a79208));
      repeat (4) @(posedge I_CLK);
      I_RESETN <= 1'b1;
      for (int a = 0; a < 256; a++) begin
         v = 8'($urandom);
         mem[a] = v;
         @(posedge I_CLK);
         I_MEM_WE <= 1'b1;
         I_MEM_ADDR <= 8'(a);
         I_MEM_WDATA <= v;
      end
      @(posedge I_CLK);
      I_MEM_WE <= 1'b0;
      do_query(8'hf8, 8'd20);
      do_query(8'($urandom), 8'd1);
      do_query(8'($urandom), PIECE_LEN);
      do_query(8'($urandom), 8'd17);
      do_query(8'($urandom), 8'd40);
      for (int f = 0; f < 8; f++) do_fault(bqf_family_e'(f), 1'b0, 2'h1, 1'b0);
      do_fault(FAM_DISCRETE, 1'b1, IOCFG_IN, 1'b0);
      do_fault(FAM_DISCRETE, 1'b1, IOCFG_OUT, 1'b0);
      do_fault(FAM_ANALOG, 1'b1, IOCFG_MIX, 1'b0);
      @(posedge I_CLK);
      I_REDUNDANT <= 1'b1;
      I_MON_SET <= 1'b1;
      I_MON_DEV <= 8'(1 + $urandom % 29);
      mon_on = 1'b1;
      @(posedge I_CLK);
      I_MON_SET <= 1'b0;
      do_fault(FAM_CS_AIO, 1'b0, 2'h3, 1'b0);
      do_fault(FAM_DISCRETE, 1'b0, 2'h1, 1'b1);
      chk_byte("fault drops", 8'd1, 8'(drop_cnt));
      do_query(8'($urandom), 8'd33);
      tally_and_finish();
   end
endmodule : tb_top

//--- verilog/bqf_engine.sv
// Block data query answer and fault notice transmitter.
`timescale 1ns/10ps
module bqf_engine (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_SCAN,
   input wire logic I_RX_VALID,
   input wire logic [7:0] I_RX_SFC,
   input wire logic [7:0] I_RX_B0,
   input wire logic [7:0] I_RX_B1,
   input wire logic [7:0] I_RX_SRC,
   input wire logic I_MON_SET,
   input wire logic [7:0] I_MON_DEV,
   input wire logic I_MEM_WE,
   input wire logic [7:0] I_MEM_ADDR,
   input wire logic [7:0] I_MEM_WDATA,
   input wire logic I_FAULT,
   input wire logic [7:0] I_FAULT_TYPE,
   input wire logic [7:0] I_FAULT_DESC,
   input wire logic [7:0] I_FAULT_CFG,
   input wire logic I_BLOCK_FAULT,
   input wire bqf_pkg::bqf_family_e I_FAMILY,
   input wire logic [1:0] I_IOCFG,
   input wire logic I_REDUNDANT,
   input wire logic [7:0] I_CTRL_DEV,
   output logic O_TX_START,
   output logic O_TX_VALID,
   output logic [7:0] O_TX_BYTE,
   output logic [7:0] O_TX_SFC,
   output logic [7:0] O_TX_DEST,
   output logic O_TX_END,
   output logic O_BUSY,
   output logic O_FAULT_DROP
);
   import bqf_pkg::*;

   logic [7:0] mem [DATA_BYTES];
   bqf_state_e state_ff;
   logic [7:0] q_off_ff, q_len_ff, q_dst_ff, sent_ff, piece_ff;
   logic [1:0] hdr_ff, idx_ff;
   logic [7:0] pay_ff [3];
   logic pend_ff, mon_vld_ff, wait_scan_ff;
   logic [7:0] mon_dev_ff;
   logic [7:0] p0, p1, p2, nxt_dest;
   logic [1:0] ncopy;

   // ----------------------------------------------------------------
   // Query data memory
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_MEM_WE) begin
         mem[I_MEM_ADDR] <= I_MEM_WDATA;
      end
   end

   // ----------------------------------------------------------------
   // Monitor assignment
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         mon_vld_ff <= 1'b0;
         mon_dev_ff <= 8'h00;
      end else if (I_MON_SET) begin
         mon_vld_ff <= 1'b1;
         mon_dev_ff <= I_MON_DEV;
      end
   end

   // ----------------------------------------------------------------
   // Fault payload formation per block family
   // ----------------------------------------------------------------
   always_comb begin
      p0 = I_FAULT_TYPE;
      p1 = I_FAULT_DESC;
      p2 = I_BLOCK_FAULT ? {6'h00, I_IOCFG} : I_FAULT_CFG;
      case (I_FAMILY)
         FAM_HSC: p1 = I_FAULT_DESC & (8'h01 << DESC_FAILED_SWITCH);
         FAM_CS_AIO: p1 = I_FAULT_DESC;
         FAM_CS_AOUT: p1 = I_FAULT_DESC & ~DESC_UNUSED_AOUT;
         FAM_CS_AIN: p1 = I_FAULT_DESC & ~DESC_UNUSED_AIN & ~(8'h01 << DESC_FEEDBACK);
         FAM_RTD_TC: begin
            p1 = I_FAULT_DESC & ~(8'h01 << DESC_FEEDBACK);
            p2 = {I_FAULT_CFG[7:2], IOCFG_IN};
         end
         FAM_GATE_ARRAY: begin
            p1 = I_FAULT_DESC & ~(8'h01 << DESC_FEEDBACK);
            p2 = 8'h00;
         end
         default: p1 = I_FAULT_DESC & ~(8'h01 << DESC_FEEDBACK);
      endcase
   end

   // ----------------------------------------------------------------
   // Copy destinations: controller(s) first, then monitor
   // ----------------------------------------------------------------
   always_comb begin
      ncopy = I_REDUNDANT ? 2'd2 : 2'd1;
      nxt_dest = I_CTRL_DEV;
      if (idx_ff == 2'd0) begin
         nxt_dest = I_REDUNDANT ? RED_DEV_A : I_CTRL_DEV;
      end else if (idx_ff == 2'd1 && I_REDUNDANT) begin
         nxt_dest = RED_DEV_B;
      end else begin
         nxt_dest = mon_dev_ff;
      end
   end

   // ----------------------------------------------------------------
   // Datagram sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state_ff <= ST_IDLE;
         q_off_ff <= 8'h00;
         q_len_ff <= 8'h00;
         q_dst_ff <= 8'h00;
         sent_ff <= 8'h00;
         piece_ff <= 8'h00;
         hdr_ff <= 2'd0;
         idx_ff <= 2'd0;
         pend_ff <= 1'b0;
         wait_scan_ff <= 1'b0;
         pay_ff[0] <= 8'h00;
         pay_ff[1] <= 8'h00;
         pay_ff[2] <= 8'h00;
         O_TX_START <= 1'b0;
         O_TX_VALID <= 1'b0;
         O_TX_BYTE <= 8'h00;
         O_TX_SFC <= 8'h00;
         O_TX_DEST <= 8'h00;
         O_TX_END <= 1'b0;
         O_BUSY <= 1'b0;
         O_FAULT_DROP <= 1'b0;
      end else begin
         O_TX_START <= 1'b0;
         O_TX_VALID <= 1'b0;
         O_TX_END <= 1'b0;
         O_FAULT_DROP <= 1'b0;
         if (I_FAULT) begin
            if (pend_ff || state_ff inside {ST_FLT_HDR, ST_FLT_DATA, ST_FLT_NEXT}) begin
               O_FAULT_DROP <= 1'b1;
            end else begin
               pend_ff <= 1'b1;
               pay_ff[0] <= p0;
               pay_ff[1] <= p1;
               pay_ff[2] <= p2;
            end
         end
         case (state_ff)
            ST_IDLE: begin
               O_BUSY <= 1'b0;
               if (I_SCAN && pend_ff) begin
                  // A fault in this same cycle was dropped above, so nothing stays pending.
                  pend_ff <= 1'b0;
                  idx_ff <= 2'd0;
                  hdr_ff <= 2'd0;
                  O_BUSY <= 1'b1;
                  state_ff <= ST_FLT_DATA;
                  O_TX_START <= 1'b1;
                  O_TX_SFC <= SFC_FAULT;
                  O_TX_DEST <= nxt_dest;
               end else if (I_RX_VALID && I_RX_SFC == SFC_QUERY) begin
                  q_off_ff <= I_RX_B0;
                  q_len_ff <= (I_RX_B1 > MAX_LEN) ? MAX_LEN : I_RX_B1;
                  q_dst_ff <= I_RX_SRC;
                  sent_ff <= 8'h00;
                  O_BUSY <= 1'b1;
                  state_ff <= ST_ANS_HDR;
                  wait_scan_ff <= 1'b0;
               end
            end
            ST_ANS_HDR: begin
               if (!wait_scan_ff || I_SCAN) begin
                  wait_scan_ff <= 1'b0;
                  O_TX_START <= 1'b1;
                  O_TX_SFC <= SFC_ANSWER;
                  O_TX_DEST <= q_dst_ff;
                  hdr_ff <= 2'd0;
                  piece_ff <= 8'h00;
                  state_ff <= ST_ANS_DATA;
               end
            end
            ST_ANS_DATA: begin
               O_TX_VALID <= 1'b1;
               if (hdr_ff == 2'd0) begin
                  O_TX_BYTE <= q_off_ff;
                  hdr_ff <= 2'd1;
               end else if (hdr_ff == 2'd1) begin
                  O_TX_BYTE <= q_len_ff;
                  hdr_ff <= 2'd2;
                  if (q_len_ff == 8'h00) begin
                     O_TX_END <= 1'b1;
                     state_ff <= ST_IDLE;
                  end
               end else begin
                  O_TX_BYTE <= mem[8'(q_off_ff + sent_ff)];
                  sent_ff <= sent_ff + 8'h01;
                  piece_ff <= piece_ff + 8'h01;
                  if (sent_ff + 8'h01 == q_len_ff) begin
                     O_TX_END <= 1'b1;
                     state_ff <= ST_IDLE;
                  end else if (piece_ff + 8'h01 == PIECE_LEN) begin
                     O_TX_END <= 1'b1;
                     wait_scan_ff <= 1'b1;
                     state_ff <= ST_ANS_HDR;
                  end
               end
            end
            ST_FLT_DATA: begin
               O_TX_VALID <= 1'b1;
               O_TX_BYTE <= pay_ff[hdr_ff];
               hdr_ff <= hdr_ff + 2'd1;
               if (hdr_ff == 2'd2) begin
                  O_TX_END <= 1'b1;
                  hdr_ff <= 2'd0;
                  // The copy index restarts so that the next notice begins at the first destination.
                  if (idx_ff + 2'd1 < ncopy + {1'b0, mon_vld_ff}) begin
                     idx_ff <= idx_ff + 2'd1;
                     state_ff <= ST_FLT_NEXT;
                  end else begin
                     idx_ff <= 2'd0;
                     state_ff <= ST_IDLE;
                  end
               end
            end
            ST_FLT_NEXT: begin
               if (I_SCAN) begin
                  O_TX_START <= 1'b1;
                  O_TX_SFC <= SFC_FAULT;
                  O_TX_DEST <= nxt_dest;
                  state_ff <= ST_FLT_DATA;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_ans_start;
      O_TX_START && O_TX_SFC == SFC_ANSWER;
   endsequence
   sequence s_ans_hdr;
      O_TX_VALID && O_TX_BYTE == $past(q_off_ff) ##1 O_TX_VALID && O_TX_BYTE == $past(q_len_ff);
   endsequence
   AST_QUERY_SEEN: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      state_ff == ST_IDLE && !(I_SCAN && pend_ff) && I_RX_VALID && I_RX_SFC == SFC_QUERY |=> state_ff == ST_ANS_HDR)
      else $error("query not accepted");
   AST_ANS_CODE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      state_ff == ST_ANS_HDR && !wait_scan_ff |=> s_ans_start)
      else $error("answer code wrong");
   AST_ANS_HDR: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      s_ans_start |=> s_ans_hdr)
      else $error("answer header wrong");
   AST_PIECE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      state_ff == ST_ANS_DATA |-> piece_ff < PIECE_LEN)
      else $error("piece exceeds sixteen bytes");
   AST_END_VALID: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      O_TX_END |-> O_TX_VALID)
      else $error("end without byte");
   AST_LEN_CAP: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      q_len_ff <= MAX_LEN)
      else $error("length above limit");
   AST_FLT_CODE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      O_TX_START && state_ff == ST_FLT_DATA |-> O_TX_SFC == SFC_FAULT)
      else $error("fault code wrong");
   AST_FLT_LEN: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      O_TX_START && O_TX_SFC == SFC_FAULT |=> O_TX_VALID [*3] ##0 O_TX_END)
      else $error("fault payload not three bytes");
   AST_GA_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      I_FAULT && I_FAMILY == FAM_GATE_ARRAY |-> p2 == 8'h00)
      else $error("gate array byte two nonzero");
   AST_RTD_IN: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      I_FAMILY == FAM_RTD_TC |-> p2[1:0] == IOCFG_IN)
      else $error("rtd config bits wrong");
   AST_HSC_ONLY: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      I_FAMILY == FAM_HSC |-> (p1 & ~(8'h01 << DESC_FAILED_SWITCH)) == 8'h00)
      else $error("counter reports other diagnostic");
   AST_RED_DEST: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
      O_TX_START && O_TX_SFC == SFC_FAULT && I_REDUNDANT && idx_ff == 2'd0 |-> O_TX_DEST == RED_DEV_A)
      else $error("redundant first copy misaddressed");
endmodule : bqf_engine

//--- verilog/bqf_pkg.sv
// Package of constants and types for the block data query and fault notice engine.
package bqf_pkg;
   // ----------------------------------------------------------------
   // Subfunction codes
   // ----------------------------------------------------------------
   localparam logic [7:0] SFC_QUERY = 8'h0c;
   localparam logic [7:0] SFC_ANSWER = 8'h0d;
   localparam logic [7:0] SFC_FAULT = 8'h0f;
   // ----------------------------------------------------------------
   // Datagram layout and limits
   // ----------------------------------------------------------------
   localparam int PIECE_BYTES = 16;
   localparam logic [7:0] PIECE_LEN = 8'h10;
   localparam logic [7:0] MAX_LEN = 8'h80;
   localparam int DATA_BYTES = 256;
   localparam logic [7:0] RED_DEV_A = 8'h1e;
   localparam logic [7:0] RED_DEV_B = 8'h1f;
   // ----------------------------------------------------------------
   // Block I/O configuration codes
   // ----------------------------------------------------------------
   localparam logic [1:0] IOCFG_IN = 2'h1;
   localparam logic [1:0] IOCFG_OUT = 2'h2;
   localparam logic [1:0] IOCFG_MIX = 2'h3;
   // ----------------------------------------------------------------
   // Fault description bits with family restrictions
   // ----------------------------------------------------------------
   localparam int DESC_FAILED_SWITCH = 0;
   localparam int DESC_FEEDBACK = 7;
   localparam logic [7:0] DESC_UNUSED_AOUT = 8'h06;
   localparam logic [7:0] DESC_UNUSED_AIN = 8'h18;
   // ----------------------------------------------------------------
   // Block families and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      FAM_DISCRETE, FAM_HSC, FAM_ANALOG, FAM_CS_AIO, FAM_CS_AOUT, FAM_CS_AIN, FAM_RTD_TC, FAM_GATE_ARRAY
   } bqf_family_e;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ANS_HDR, ST_ANS_DATA, ST_FLT_HDR, ST_FLT_DATA, ST_FLT_NEXT
   } bqf_state_e;
endpackage : bqf_pkg
